// [video_capture_defs.svh]
`ifndef VIDEO_CAPTURE_DEFS_SVH
`define VIDEO_CAPTURE_DEFS_SVH
// =============================================================
// Constants of the input capture port
`define VC_PIX_W 24
`define VC_FIFO_DEPTH 32
`define VC_CNT_W 12
`define VC_SV_W 8
`define VC_LINE_FIRST 12'h001
`define VC_BLANK_LEAD 13'h0002
`define VC_LREQ_VS_DELAY 4'h9
`define VC_FLUSH_CLKS 4'h4
// Mode bit positions in the pixel mode select word
`define VC_MB_DBL 3
`define VC_MB_OFS 2
`define VC_MB_BSEL 1
`define VC_MB_RGB 0
`endif

// [video_capture_pkg.sv]
// =============================================================
// Types of the input capture port
package video_capture_pkg;
	typedef enum logic [4:0]
	{
		PM_SINGLE_A = 5'b00001,
		PM_SINGLE_B = 5'b00010,
		PM_DOUBLE = 5'b00100,
		PM_OFFSET = 5'b01000,
		PM_YUV = 5'b10000
	} pix_mode_t;
	typedef enum logic [3:0]
	{
		LS_WAIT_VS = 4'b0001,
		LS_DELAY = 4'b0010,
		LS_REQ = 4'b0100,
		LS_FLUSH = 4'b1000
	} lreq_state_t;
	typedef enum logic [2:0]
	{
		ZM_NONE = 3'b001,
		ZM_STD = 3'b010,
		ZM_DEINT = 3'b100
	} zoom_mode_t;
endpackage

// [capture_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Pixel FIFO with a registered output stage
module capture_fifo #(
	parameter int W = 48,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ov_q, ov_d;
	logic [W-1:0] od_q, od_d;
	logic push, load;
	// Room left in storage
	assign in_ready_o = (cnt_q != FULL);
	assign out_valid_o = ov_q;
	assign out_data_o = od_q;
	// Next pointers, count and output stage
	always_comb
	begin
		push = in_valid_i && in_ready_o;
		load = (cnt_q != '0) && (!ov_q || out_ready_i);
		wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d = load ? AW'(rd_q + 1'b1) : rd_q;
		cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(load);
		ov_d = load ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
		od_d = load ? mem_q[rd_q] : od_q;
	end
	// Registers
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end
	// Storage, written by index
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end
endmodule
`default_nettype wire

// [video_input_capture_port.sv]
// How it works
// - Low line request when ready for a line
// - Drop request after line, hold through flush
// - Request held until programmed pixels transferred
// - Pixels 24-bit single or 48-bit pair
// - Four mode bits select the pixel mode
// - Single mode samples syncs on qualified clocks
// - Single mode captures only inside active region
// - Data two sampling ticks after blank edges
// - Double mode samples both buses, counts qualified
// - Offset mode samples and counts every clock
// - Offset mode: qualifier picks A or B
// - Syncs sampled on selected pixel clock edge
// - Without interlace, equal windows, zero scales give no zoom
// - Without interlace, larger output window gives standard zoom
// - Interlaced fields get de-interlacing zoom
// - Odd indicator marks upper field, invertible
// - Only active window pixels feed the scaler
// - Field picks one of two vertical starts
// - Vsync sets line one, request nine clocks later
// - Blank lifts two sampling ticks early
`timescale 1ns/1ps
`default_nettype none
`include "video_capture_defs.svh"
// =============================================================
// Input capture port
module video_input_capture_port #(
	parameter int CW = `VC_CNT_W,
	parameter int SVW = `VC_SV_W,
	parameter int FIFO_DEPTH = `VC_FIFO_DEPTH,
	parameter logic [3:0] FLUSH_CLKS = `VC_FLUSH_CLKS
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Input port pins
	input wire logic port_a_pixel_clock_i,
	input wire logic port_a_hsync_i,
	input wire logic port_a_vsync_i,
	input wire logic port_a_clock_qualifier_i,
	input wire logic port_b_clock_qualifier_i,
	input wire logic odd_field_indicator_i,
	input wire logic [`VC_PIX_W-1:0] port_a_data_i,
	input wire logic [`VC_PIX_W-1:0] port_b_data_i,
	output logic line_request_n_o,
	output logic active_blank_n_o,
	// Mode control
	input wire logic double_width_enable_i,
	input wire logic double_offset_enable_i,
	input wire logic port_b_select_i,
	input wire logic rgb_input_enable_i,
	input wire logic odd_polarity_invert_i,
	input wire logic interlace_enable_i,
	input wire logic pclk_rise_sel_i,
	input wire logic hsync_active_high_i,
	input wire logic vsync_active_high_i,
	input wire logic qualifier_active_high_i,
	// Window and scale setup
	input wire logic [CW-1:0] in_h_active_start_i,
	input wire logic [CW-1:0] in_h_active_width_i,
	input wire logic [CW-1:0] in_v_start_upper_field_i,
	input wire logic [CW-1:0] in_v_start_lower_field_i,
	input wire logic [CW-1:0] in_v_active_length_i,
	input wire logic [CW-1:0] out_h_active_width_i,
	input wire logic [CW-1:0] out_v_active_length_i,
	input wire logic [SVW-1:0] h_scale_value_i,
	input wire logic [SVW-1:0] v_scale_value_i,
	// Status
	output video_capture_pkg::zoom_mode_t zoom_mode_o,
	output logic field_upper_o,
	// Pixel stream to the scaler
	output logic pix_valid_o,
	input wire logic pix_ready_i,
	output logic [2*`VC_PIX_W-1:0] pix_data_o
);
	import video_capture_pkg::*;
	localparam int PW = `VC_PIX_W;

	// =============================================================
	// Helpers
	// Mode decode from the four select bits
	function automatic pix_mode_t mode_of(input logic [3:0] b);
		case (b)
			4'b0001: mode_of = PM_SINGLE_A;
			4'b0011: mode_of = PM_SINGLE_B;
			4'b1001: mode_of = PM_DOUBLE;
			4'b0101: mode_of = PM_OFFSET;
			4'b0000: mode_of = PM_YUV;
			default: mode_of = PM_SINGLE_A;
		endcase
	endfunction
	// Position inside start plus length
	function automatic logic in_span(input logic [CW:0] pos, input logic [CW-1:0] st,
		input logic [CW-1:0] len);
		in_span = (pos >= {1'b0, st}) && (pos < ({1'b0, st} + {1'b0, len}));
	endfunction
	// Last position of a span
	function automatic logic at_end(input logic [CW:0] pos, input logic [CW-1:0] st,
		input logic [CW-1:0] len);
		at_end = (len != '0) && (pos == ({1'b0, st} + {1'b0, len} - 1'b1));
	endfunction

	// =============================================================
	// Pin synchronisers
	localparam int SW = 6 + 2*PW;
	logic [SW-1:0] meta_q, sync_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= {port_a_pixel_clock_i, port_a_hsync_i, port_a_vsync_i,
				port_a_clock_qualifier_i, port_b_clock_qualifier_i, odd_field_indicator_i,
				port_b_data_i, port_a_data_i};
			sync_q <= meta_q;
		end
	end
	logic pclk_s, hs_s, vs_s, qa_s, qb_s, odd_s;
	logic [PW-1:0] da_s, db_s;
	assign {pclk_s, hs_s, vs_s, qa_s, qb_s, odd_s, db_s, da_s} = sync_q;

	// =============================================================
	// Capture state
	logic pclk_prev_q, hs_prev_q, vs_prev_q, field_q, field_d;
	logic [CW-1:0] hcnt_q, hcnt_d, line_q, line_d;
	logic [PW-1:0] hold_a_q, hold_a_d;
	lreq_state_t st_q, st_d;
	logic [3:0] dly_q, dly_d;
	logic lreq_n_q, lreq_n_d, blank_n_q, blank_n_d;
	zoom_mode_t zoom_q, zoom_d;
	pix_mode_t mode;
	logic pix_edge, tick, qa_act, qb_act, hs_evt, vs_evt, v_act, cap, last_cap;
	logic last_line, push;
	logic [CW-1:0] vstart;
	logic [2*PW-1:0] push_data;
	logic fifo_ready;

	// Next values of the capture logic
	always_comb
	begin
		mode = mode_of({double_width_enable_i, double_offset_enable_i,
			port_b_select_i, rgb_input_enable_i});
		// Selected pixel clock edge
		pix_edge = pclk_rise_sel_i ? (pclk_s && !pclk_prev_q)
			: (!pclk_s && pclk_prev_q);
		qa_act = qualifier_active_high_i ? qa_s : !qa_s;
		qb_act = qualifier_active_high_i ? qb_s : !qb_s;
		// Sampling tick per mode
		case (mode)
			PM_OFFSET: tick = pix_edge;
			PM_SINGLE_B, PM_YUV: tick = pix_edge && qb_act;
			default: tick = pix_edge && qa_act;
		endcase
		hs_evt = tick && (hsync_active_high_i ? hs_s : !hs_s) && !hs_prev_q;
		vs_evt = tick && (vsync_active_high_i ? vs_s : !vs_s) && !vs_prev_q;
		// Line counter and field
		line_d = line_q;
		field_d = field_q;
		if (vs_evt)
			line_d = `VC_LINE_FIRST;
		else if (hs_evt)
			line_d = CW'(line_q + 1'b1);
		vstart = field_q ? in_v_start_upper_field_i : in_v_start_lower_field_i;
		if (hs_evt && !in_span({1'b0, line_q}, vstart, in_v_active_length_i))
			field_d = interlace_enable_i ? (odd_s ^ odd_polarity_invert_i) : 1'b1;
		vstart = field_d ? in_v_start_upper_field_i : in_v_start_lower_field_i;
		v_act = in_span({1'b0, line_d}, vstart, in_v_active_length_i);
		last_line = at_end({1'b0, line_d}, vstart, in_v_active_length_i);
		// Horizontal counter
		hcnt_d = hcnt_q;
		if (hs_evt)
			hcnt_d = '0;
		else if (tick && (hcnt_q != '1))
			hcnt_d = CW'(hcnt_q + 1'b1);
		cap = tick && v_act && in_span({1'b0, hcnt_d}, in_h_active_start_i,
			in_h_active_width_i);
		last_cap = cap && at_end({1'b0, hcnt_d}, in_h_active_start_i, in_h_active_width_i);
		// Blank leads the capture by two ticks
		blank_n_d = blank_n_q;
		if (tick)
			blank_n_d = !(v_act && in_span({1'b0, hcnt_d} + `VC_BLANK_LEAD,
				in_h_active_start_i, in_h_active_width_i));
		// Pixel assembly
		hold_a_d = hold_a_q;
		push = 1'b0;
		push_data = {{PW{1'b0}}, da_s};
		case (mode)
			PM_OFFSET:
			begin
				if (cap && qa_act)
					hold_a_d = da_s;
				push = cap && !qa_act;
				push_data = {db_s, hold_a_q};
			end
			PM_DOUBLE:
			begin
				push = cap;
				push_data = {db_s, da_s};
			end
			PM_SINGLE_B, PM_YUV:
			begin
				push = cap;
				push_data = {{PW{1'b0}}, db_s};
			end
			default:
			begin
				push = cap;
				push_data = {{PW{1'b0}}, da_s};
			end
		endcase
		// Line request sequencing
		st_d = st_q;
		dly_d = dly_q;
		case (st_q)
			LS_WAIT_VS:
				st_d = LS_WAIT_VS;
			LS_DELAY:
			begin
				if (pix_edge)
					dly_d = 4'(dly_q + 1'b1);
				if (pix_edge && (dly_q == 4'(`VC_LREQ_VS_DELAY - 1'b1)))
					st_d = LS_REQ;
			end
			LS_REQ:
			begin
				if (last_cap)
				begin
					st_d = last_line ? LS_WAIT_VS : LS_FLUSH;
					dly_d = '0;
				end
			end
			LS_FLUSH:
			begin
				if (pix_edge && (dly_q != 4'hF))
					dly_d = 4'(dly_q + 1'b1);
				if ((dly_q >= 4'(FLUSH_CLKS - 1'b1)) && pix_edge && fifo_ready)
					st_d = LS_REQ;
			end
			default:
				st_d = LS_WAIT_VS;
		endcase
		if (vs_evt)
		begin
			st_d = LS_DELAY;
			dly_d = '0;
		end
		lreq_n_d = (st_d != LS_REQ);
		// Operating mode
		if (interlace_enable_i)
			zoom_d = ZM_DEINT;
		else if ((in_h_active_width_i == out_h_active_width_i)
			&& (in_v_active_length_i == out_v_active_length_i)
			&& (h_scale_value_i == '0) && (v_scale_value_i == '0))
			zoom_d = ZM_NONE;
		else
			zoom_d = ZM_STD;
	end

	// Registers of the capture logic
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pclk_prev_q <= 1'b0;
			hs_prev_q <= 1'b0;
			vs_prev_q <= 1'b0;
			field_q <= 1'b1;
			hcnt_q <= '1;
			line_q <= '0;
			hold_a_q <= '0;
			st_q <= LS_WAIT_VS;
			dly_q <= '0;
			lreq_n_q <= 1'b1;
			blank_n_q <= 1'b1;
			zoom_q <= ZM_NONE;
		end
		else
		begin
			pclk_prev_q <= pclk_s;
			if (tick)
			begin
				hs_prev_q <= hsync_active_high_i ? hs_s : !hs_s;
				vs_prev_q <= vsync_active_high_i ? vs_s : !vs_s;
			end
			field_q <= field_d;
			hcnt_q <= hcnt_d;
			line_q <= line_d;
			hold_a_q <= hold_a_d;
			st_q <= st_d;
			dly_q <= dly_d;
			lreq_n_q <= lreq_n_d;
			blank_n_q <= blank_n_d;
			zoom_q <= zoom_d;
		end
	end

	assign line_request_n_o = lreq_n_q;
	assign active_blank_n_o = blank_n_q;
	assign zoom_mode_o = zoom_q;
	assign field_upper_o = field_q;

	// =============================================================
	// Pixel buffer toward the scaler
	capture_fifo #(
		.W(2*PW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(push),
		.in_ready_o(fifo_ready),
		.in_data_i(push_data),
		.out_valid_o(pix_valid_o),
		.out_ready_i(pix_ready_i),
		.out_data_o(pix_data_o)
	);

	// =============================================================
	// Checks
	// Blank history over the last two ticks
	logic [1:0] bh_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			bh_q <= 2'h3;
		else if (tick)
			bh_q <= {bh_q[0], blank_n_d};
	end
	chk_vs_line_one: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		vs_evt |=> (line_q == `VC_LINE_FIRST) && (st_q == LS_DELAY))
		else $error("vsync did not restart the line count");
	chk_req_nine_edges: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(st_q == LS_DELAY) && pix_edge && (dly_q == 4'h8) && !vs_evt |=> !lreq_n_q)
		else $error("line request not raised on ninth edge");
	chk_req_held: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!lreq_n_q && !last_cap && !vs_evt |=> !lreq_n_q)
		else $error("line request dropped before the line ended");
	chk_req_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(st_q == LS_REQ) && last_cap && !vs_evt |=> lreq_n_q ##1 lreq_n_q)
		else $error("line request not dropped after last pixel");
	chk_blank_lead: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		cap && !hs_evt && (hcnt_d >= CW'(2)) |-> !bh_q[1])
		else $error("pixel taken without blank lifted two ticks before");
	chk_hcnt_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		hs_evt |=> (hcnt_q == '0))
		else $error("hsync did not clear the pixel counter");
	chk_offset_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(mode == PM_OFFSET) && cap |-> (push == !qa_act))
		else $error("offset mode pushed on the wrong phase");
	chk_zoom_none: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!interlace_enable_i && (in_h_active_width_i == out_h_active_width_i)
		&& (in_v_active_length_i == out_v_active_length_i) && (h_scale_value_i == '0)
		&& (v_scale_value_i == '0) ##1 $stable(in_h_active_width_i) |-> zoom_q == ZM_NONE)
		else $error("no zoom mode not selected");
	chk_field_pol: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		hs_evt && interlace_enable_i && !in_span({1'b0, line_q}, vstart, in_v_active_length_i)
		&& (field_q == field_d) |=> field_q == ($past(odd_s) ^ $past(odd_polarity_invert_i)))
		else $error("field polarity not applied");
	chk_no_cap_outside: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		push |-> cap)
		else $error("pixel pushed outside the active window");
endmodule
`default_nettype wire

// [video_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Frame buffer source that answers line requests
module video_source_model (
	// Pixel pins
	output logic pclk_o,
	output logic hs_o,
	output logic vs_o,
	output logic qual_o,
	output logic odd_o,
	output logic [23:0] a_o,
	output logic [23:0] b_o,
	// Handshake from the capture port
	input wire logic req_n_i,
	input wire logic blank_n_i
);
	int cyc = 0;
	int tk = 0;
	int req_at = -1;
	int rise_at = -1;
	int lo_first = -1;
	int lo_cnt = 0;
	bit alt = 1'b0;
	bit every = 1'b1;
	bit armed = 1'b0;
	// Pixel clock stands still until a frame starts
	initial
	begin
		pclk_o = 1'b0;
		hs_o = 1'b0;
		vs_o = 1'b0;
		qual_o = 1'b1;
		odd_o = 1'b1;
		a_o = 24'h000000;
		b_o = 24'h000000;
	end
	// One pixel clock; pins move only while it is low, off the system clock edges
	task cycle(input bit h, input bit v);
		bit q;
		begin
			#1;
			q = !alt || !cyc[0];
			hs_o = h;
			vs_o = v;
			qual_o = q;
			a_o = {8'hA0, cyc[15:0]};
			b_o = {8'hB0, cyc[15:0]};
			#22;
			// Blank seen on qualified edges, or on every edge when every is set, as a buffered source would
			if (q || every)
			begin
				if (!blank_n_i)
				begin
					lo_cnt++;
					if (lo_first < 0)
						lo_first = tk;
				end
				tk++;
			end
			// A request still standing from before the sync is not counted
			if (req_n_i === 1'b1)
				armed = 1'b1;
			else if (armed && req_at < 0)
				req_at = cyc;
			if (req_n_i && rise_at < 0)
				rise_at = cyc;
			pclk_o = 1'b1;
			#24;
			pclk_o = 1'b0;
			#1;
			cyc++;
		end
	endtask
	// Start of field; odd indicator held for the whole field
	task vsync(input bit a, input bit e, input bit odd);
		begin
			alt = a;
			every = e;
			odd_o = odd;
			cyc = 0;
			req_at = -1;
			armed = 1'b0;
			repeat (2) cycle(1'b0, 1'b1);
			while (req_at < 0 && cyc < 40)
				cycle(1'b0, 1'b0);
		end
	endtask
	// Wait for the request, then hsync, blanking and pixels
	task line(input int len);
		begin
			cyc = 0;
			while (req_n_i === 1'b1 && cyc < 200)
				cycle(1'b0, 1'b0);
			cyc = 0;
			tk = 0;
			rise_at = -1;
			lo_first = -1;
			lo_cnt = 0;
			repeat (2) cycle(1'b1, 1'b0);
			while (cyc < len)
				cycle(1'b0, 1'b0);
		end
	endtask
	// Clock runs with no syncs
	task idle(input int n);
		repeat (n) cycle(1'b0, 1'b0);
	endtask
endmodule
`default_nettype wire

// [video_input_capture_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Bench for the input capture port
module video_input_capture_port_test;
	import video_capture_pkg::*;
	localparam int HS = 4;
	localparam int FIFO_DEPTH = 32;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] mode = 4'h1;
	logic inv = 1'b0;
	logic ilace = 1'b0;
	logic qpol = 1'b1;
	logic hpol = 1'b1;
	logic [11:0] hst = 12'h004;
	logic [11:0] vup = 12'h002;
	logic [11:0] vlo = 12'h014;
	logic [11:0] vlen = 12'h002;
	logic [11:0] in_w = 12'h004;
	logic [11:0] out_w = 12'h004;
	logic [11:0] out_l = 12'h002;
	logic [7:0] sv = 8'h00;
	logic ready = 1'b1;
	wire pclk, hs, vs, qual, odd, req_n, blank_n, fup, pv;
	wire [23:0] pa, pb;
	wire [47:0] pd;
	zoom_mode_t zm;
	logic [47:0] q[$];
	logic [3:0] modes[5] = '{4'h1, 4'h3, 4'h9, 4'h5, 4'h0};
	int compares = 0;
	int miscompares = 0;
	// System clock, 4 ns
	always #2 clk = ~clk;
	video_source_model src (
		.pclk_o(pclk),
		.hs_o(hs),
		.vs_o(vs),
		.qual_o(qual),
		.odd_o(odd),
		.a_o(pa),
		.b_o(pb),
		.req_n_i(req_n),
		.blank_n_i(blank_n)
	);
	video_input_capture_port uut (
		.clk_sys_i(clk),
		.rst_b_i(rst_b),
		.port_a_pixel_clock_i(pclk),
		.port_a_hsync_i(hs ^ !hpol),
		.port_a_vsync_i(vs),
		.port_a_clock_qualifier_i(qual ^ !qpol),
		.port_b_clock_qualifier_i(qual ^ !qpol),
		.odd_field_indicator_i(odd),
		.port_a_data_i(pa),
		.port_b_data_i(pb),
		.line_request_n_o(req_n),
		.active_blank_n_o(blank_n),
		.double_width_enable_i(mode[3]),
		.double_offset_enable_i(mode[2]),
		.port_b_select_i(mode[1]),
		.rgb_input_enable_i(mode[0]),
		.odd_polarity_invert_i(inv),
		.interlace_enable_i(ilace),
		.pclk_rise_sel_i(1'b1),
		.hsync_active_high_i(hpol),
		.vsync_active_high_i(1'b1),
		.qualifier_active_high_i(qpol),
		.in_h_active_start_i(hst),
		.in_h_active_width_i(in_w),
		.in_v_start_upper_field_i(vup),
		.in_v_start_lower_field_i(vlo),
		.in_v_active_length_i(vlen),
		.out_h_active_width_i(out_w),
		.out_v_active_length_i(out_l),
		.h_scale_value_i(sv),
		.v_scale_value_i(sv),
		.zoom_mode_o(zm),
		.field_upper_o(fup),
		.pix_valid_o(pv),
		.pix_ready_i(ready),
		.pix_data_o(pd)
	);
	// Words taken from the scaler stream
	always @(posedge clk)
		if (pv === 1'b1 && ready === 1'b1)
			q.push_back(pd);
	task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		begin
			compares++;
			if (seen !== exp)
			begin
				miscompares++;
				$display("ERROR %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// Word j of a line as the source laid it out
	function automatic logic [47:0] exp_word(input logic [3:0] m, input int j);
		int c;
		begin
			c = HS + j;
			case (m)
				4'h9: exp_word = {8'hB0, 16'(2 * c), 8'hA0, 16'(2 * c)};
				4'h5: exp_word = {8'hB0, 16'(HS + 2 * j + 1), 8'hA0, 16'(HS + 2 * j)};
				4'h3, 4'h0: exp_word = {24'h000000, 8'hB0, 16'(c)};
				default: exp_word = {24'h000000, 8'hA0, 16'(c)};
			endcase
		end
	endfunction
	task zcase(input logic [11:0] ow, input logic [11:0] ol, input logic [7:0] s,
		input zoom_mode_t e);
		begin
			@(posedge clk);
			out_w <= ow;
			out_l <= ol;
			sv <= s;
			repeat (3) @(posedge clk);
			check("zoom", zm, e);
		end
	endtask
	// One field of two lines; st stalls the stream through the first line
	task frame(input logic [3:0] m, input bit odd, input bit nact, input bit st, input int wd);
		int wpl;
		int n1;
		begin
			@(posedge clk);
			mode <= m;
			in_w <= 12'(wd);
			ready <= !st;
			wpl = m[2] ? wd / 2 : wd;
			n1 = st ? FIFO_DEPTH + 1 : wpl;
			q.delete();
			src.vsync(m[3] | m[2], !m[3], odd);
			check("req_delay", src.req_at, 10);
			for (int ln = 0; ln < 2; ln++)
			begin
				src.line(2 * (HS + wd) + 6);
				check("blank_first", src.lo_first, nact ? HS - 1 : -1);
				check("blank_len", src.lo_cnt, nact ? wd : 0);
				if (nact)
					check("req_rise", src.rise_at, m[3] ? 2 * (HS + wd) - 1 : HS + wd);
				if (st && ln == 0)
				begin
					src.idle(20);
					check("req_full", req_n, 1'b1);
					@(posedge clk);
					ready <= 1'b1;
				end
			end
			src.idle(20);
			if (nact)
				check("req_end", req_n, 1'b1);
			repeat (100) @(posedge clk);
			check("words", q.size(), nact ? n1 + wpl : 0);
			foreach (q[i])
				check("pixel", q[i], exp_word(m, i < n1 ? i : i - n1));
		end
	endtask
	// Hang guard, well past the expected run
	initial
	begin
		#300000;
		miscompares++;
		give_verdict();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		check("req_rst", req_n, 1'b1);
		check("blank_rst", blank_n, 1'b1);
		check("valid_rst", pv, 1'b0);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		zcase(12'h004, 12'h002, 8'h00, ZM_NONE);
		zcase(12'h008, 12'h004, 8'h10, ZM_STD);
		zcase(12'h004, 12'h002, 8'h01, ZM_STD);
		zcase(12'h004, 12'h002, 8'h00, ZM_NONE);
		foreach (modes[k])
			frame(modes[k], 1'b1, 1'b1, 1'b0, 4);
		// Qualifier and hsync pins active low; A and B phases must not swap
		qpol <= 1'b0;
		hpol <= 1'b0;
		frame(4'h5, 1'b1, 1'b1, 1'b0, 4);
		qpol <= 1'b1;
		hpol <= 1'b1;
		frame(4'h1, 1'b1, 1'b1, 1'b1, 40);
		for (int f = 0; f < 3; f++)
		begin
			@(posedge clk);
			ilace <= 1'b1;
			inv <= (f == 2);
			zcase(12'h004, 12'h002, 8'h00, ZM_DEINT);
			frame(4'h1, f == 0, f != 1, 1'b0, 4);
			check("field", fup, f != 1);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
